// ===== include/kps_defines.vh
// Contract
// [RULE1] Status bit reads 0 busy, 1 idle
// [RULE2] Writing 0 allows continuous repeated scanning
// [RULE3] Writing 1 stops scanning immediately
// [RULE4] Bits 13:11 select de-bounce time
// [RULE5] Set mask bit excludes key from detection
// [RULE6] Masked key never asserts keypad interrupt
// [RULE7] Key mask resets to all zeros
// [RULE8] Key index is 4*row plus column
// [RULE9] Result word has one per pressed key
// [RULE10] Three rectangle corners may ghost the fourth
// [RULE11] Secondary bit 15 reads data-available pin
// [RULE12] Secondary write bits 15:14 select release events
// [RULE13] Interrupt low on press, high on release
// [RULE14] Release A: hardware or software reset
// [RULE15] Release B stop, C key up, D read
// [RULE16] Encoding 00 ABC, 01 AB, 10 ABCD, 11 ABD
// [RULE17] Pressed status bit is inverse of interrupt
// [RULE18] Latch only after stable whole de-bounce time
`ifndef KPS_DEFINES_VH
`define KPS_DEFINES_VH

// ****************************************************************
// Register map (page bit, 6-bit address)
// ****************************************************************
`define KPS_PAGE_DATA      1'b0
`define KPS_PAGE_CTRL      1'b1
`define KPS_ADDR_KEYDATA   6'h04
`define KPS_ADDR_KEYCTRL   6'h01
`define KPS_ADDR_SOFTRST   6'h04
`define KPS_ADDR_SECCFG    6'h06
`define KPS_ADDR_KEYMASK   6'h10
`define KPS_SOFTRST_CODE   16'hBB00

// ****************************************************************
// Fields
// ****************************************************************
`define KPS_CTRL_STATUS    15
`define KPS_CTRL_SCS       14
`define KPS_CTRL_DB_HI     13
`define KPS_CTRL_DB_LO     11
`define KPS_SEC_HI         15
`define KPS_SEC_LO         14

// ****************************************************************
// Reset values
// ****************************************************************
`define KPS_RST_MASK       16'h0000
`define KPS_RST_DB         3'h0
`define KPS_RST_REL        2'h3
`define KPS_RST_REL_HI     1'b1
`define KPS_RST_REL_LO     1'b1
`define KPS_RST_SCS        1'b0

// ****************************************************************
// Release selections
// ****************************************************************
`define KPS_REL_ABC        2'h0
`define KPS_REL_AB         2'h1
`define KPS_REL_ABCD       2'h2
`define KPS_REL_ABD        2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define KPS_CLK_KHZ        10000
`define KPS_MS_PER_MS      1
`define KPS_SETTLE_CYC     4'h8
`define KPS_DB_000         7'h02
`define KPS_DB_001         7'h0A
`define KPS_DB_010         7'h14
`define KPS_DB_011         7'h32
`define KPS_DB_100         7'h3C
`define KPS_DB_101         7'h50
`define KPS_DB_110         7'h64
`define KPS_DB_111         7'h78

`endif

// ===== rtl/kps_debounce.v
`timescale 1ns/1ps
`default_nettype none
`include "kps_defines.vh"

module kps_debounce #(
  parameter MS_CYCLES = `KPS_CLK_KHZ * `KPS_MS_PER_MS
) (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rstn,
  // Control
  input  wire       clr,
  input  wire       run,
  input  wire [2:0] sel,
  // Status
  output wire       done
);

  reg  [15:0] div_r;
  reg  [6:0]  ms_r;
  reg  [6:0]  target;
  wire        ms_tick;

  // ****************************************************************
  // Selected de-bounce time in whole milliseconds
  // ****************************************************************
  always @* begin
    case (sel) // [RULE4]
      3'h0:    target = `KPS_DB_000;
      3'h1:    target = `KPS_DB_001;
      3'h2:    target = `KPS_DB_010;
      3'h3:    target = `KPS_DB_011;
      3'h4:    target = `KPS_DB_100;
      3'h5:    target = `KPS_DB_101;
      3'h6:    target = `KPS_DB_110;
      default: target = `KPS_DB_111;
    endcase
  end

  // Divider restarts with the window so the first millisecond is whole
  assign ms_tick = (div_r == MS_CYCLES[15:0] - 16'h0001);

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_r <= 16'h0000;
      ms_r  <= 7'h00;
    end else if (clr || !run) begin
      div_r <= 16'h0000;
      ms_r  <= 7'h00;
    end else if (ms_tick) begin
      div_r <= 16'h0000;
      if (!done)
        ms_r <= ms_r + 7'h01;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  assign done = (ms_r >= target); // [RULE18]

endmodule // kps_debounce
`default_nettype wire

// ===== rtl/kps_scan.v
`timescale 1ns/1ps
`default_nettype none
`include "kps_defines.vh"

module kps_scan #(
  parameter MS_CYCLES = `KPS_CLK_KHZ * `KPS_MS_PER_MS
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // Register access from the serial decoder
  input  wire        reg_page,
  input  wire [5:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  // Key matrix
  output reg  [3:0]  row_drive_n,
  input  wire [3:0]  col_sense_n,
  // Status pins
  output wire        key_irq_n,
  output wire        data_avail_pin
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_DRIVE = 2'h1;
  localparam ST_EVAL  = 2'h2;

  reg  [1:0]  state_r;
  reg  [1:0]  row_r;
  reg  [3:0]  settle_r;
  reg  [15:0] raw_r;
  reg  [15:0] cand_r;
  reg         latched_r;
  reg         pressed_r;
  reg  [15:0] key_mask_bits;
  reg  [15:0] key_data_r;
  reg  [2:0]  debounce_select;
  reg         stop_r;
  reg         irq_release_sel_hi;
  reg         irq_release_sel_lo;
  reg         irq_act_r;
  reg         avail_r;
  reg  [3:0]  s1_r;
  reg  [3:0]  s2_r;
  reg  [3:0]  s3_r;
  reg  [3:0]  col_r;
  reg  [3:0]  row_nxt;
  wire [15:0] key_word;
  wire        db_done;
  wire        db_clr;
  wire        busy;
  wire        soft_rst;
  wire        wr_ctrl;
  wire        wr_sec;
  wire        wr_mask;
  wire        rd_data;
  wire        stop_wr;
  wire        latch_ev;
  wire        release_c;
  wire        rel_c_en;
  wire        rel_d_en;
  wire        irq_clr;
  wire        key_pressed_status;
  wire        scan_busy_stop;
  wire        data_avail_status;

  // ****************************************************************
  // Register strobes
  // ****************************************************************
  assign wr_ctrl  = reg_wr && reg_page == `KPS_PAGE_CTRL
                    && reg_addr == `KPS_ADDR_KEYCTRL;
  assign wr_sec   = reg_wr && reg_page == `KPS_PAGE_CTRL
                    && reg_addr == `KPS_ADDR_SECCFG;
  assign wr_mask  = reg_wr && reg_page == `KPS_PAGE_CTRL
                    && reg_addr == `KPS_ADDR_KEYMASK;
  assign soft_rst = reg_wr && reg_page == `KPS_PAGE_CTRL
                    && reg_addr == `KPS_ADDR_SOFTRST
                    && reg_wdata == `KPS_SOFTRST_CODE; // [RULE14]
  assign rd_data  = reg_rd && reg_page == `KPS_PAGE_DATA
                    && reg_addr == `KPS_ADDR_KEYDATA;
  assign stop_wr  = wr_ctrl && reg_wdata[`KPS_CTRL_SCS]; // [RULE15]

  // ****************************************************************
  // Column inputs: three flops, accepted when the last two agree
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          s1_r[gi]  <= 1'b1;
          s2_r[gi]  <= 1'b1;
          s3_r[gi]  <= 1'b1;
          col_r[gi] <= 1'b1;
        end else begin
          s1_r[gi] <= col_sense_n[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi])
            col_r[gi] <= s3_r[gi];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Scan sequencer
  // ****************************************************************
  // Masked keys vanish here, so they can neither raise nor hold the irq
  assign key_word  = raw_r & ~key_mask_bits; // [RULE5] [RULE6]
  assign busy      = (state_r != ST_IDLE);
  assign latch_ev  = (state_r == ST_EVAL) && (key_word != 16'h0000)
                     && (key_word == cand_r) && db_done && !latched_r
                     && !stop_wr;
  assign release_c = (state_r == ST_EVAL) && (key_word == 16'h0000)
                     && pressed_r; // [RULE15]
  assign db_clr    = (state_r == ST_EVAL) && (key_word != cand_r);

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r   <= ST_IDLE;
      row_r     <= 2'h0;
      settle_r  <= 4'h0;
      raw_r     <= 16'h0000;
      cand_r    <= 16'h0000;
      latched_r <= 1'b0;
      pressed_r <= 1'b0;
    end else if (soft_rst || stop_wr || stop_r) begin
      // A stop aborts at once even with a key held down
      state_r   <= ST_IDLE; // [RULE3]
      row_r     <= 2'h0;
      settle_r  <= 4'h0;
      cand_r    <= 16'h0000;
      latched_r <= 1'b0;
      pressed_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          row_r    <= 2'h0;
          settle_r <= 4'h0;
          if (col_r != 4'hF)
            state_r <= ST_DRIVE;
        end
        ST_DRIVE: begin
          if (settle_r == `KPS_SETTLE_CYC) begin
            settle_r <= 4'h0;
            // Passive matrix: three corners pull in the fourth
            raw_r[{row_r, 2'b00} +: 4] <= ~col_r; // [RULE8] [RULE10]
            row_r <= row_r + 2'h1;
            if (row_r == 2'h3)
              state_r <= ST_EVAL;
          end else begin
            settle_r <= settle_r + 4'h1;
          end
        end
        ST_EVAL: begin
          cand_r <= key_word;
          if (key_word == 16'h0000) begin
            latched_r <= 1'b0;
            pressed_r <= 1'b0;
            state_r   <= ST_IDLE;
          end else begin
            if (key_word != cand_r)
              latched_r <= 1'b0;
            if (latch_ev) begin
              latched_r <= 1'b1;
              pressed_r <= 1'b1;
            end
            // Keep rescanning while held; new patterns re-debounce
            state_r <= ST_DRIVE; // [RULE2]
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  kps_debounce #(
    .MS_CYCLES (MS_CYCLES)
  ) u_debounce (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .clr     (db_clr),
    .run     (busy),
    .sel     (debounce_select),
    .done    (db_done)
  );

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      row_drive_n <= 4'hF;
    // Rows let go in the stop cycle itself, not one cycle later
    else if (stop_wr || soft_rst)
      row_drive_n <= 4'hF; // [RULE3]
    else if (state_r == ST_DRIVE)
      row_drive_n <= row_nxt;
    else if (state_r == ST_IDLE && !stop_r)
      row_drive_n <= 4'h0;
    else
      row_drive_n <= 4'hF;
  end

  always @* begin
    row_nxt = 4'hF;
    row_nxt[row_r] = 1'b0;
  end

  // ****************************************************************
  // Control registers and result
  // ****************************************************************
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      key_mask_bits      <= `KPS_RST_MASK; // [RULE7]
      debounce_select    <= `KPS_RST_DB;
      stop_r             <= `KPS_RST_SCS;
      irq_release_sel_hi <= `KPS_RST_REL_HI;
      irq_release_sel_lo <= `KPS_RST_REL_LO;
      key_data_r         <= 16'h0000;
    end else if (soft_rst) begin
      key_mask_bits      <= `KPS_RST_MASK; // [RULE7]
      debounce_select    <= `KPS_RST_DB;
      stop_r             <= `KPS_RST_SCS;
      irq_release_sel_hi <= `KPS_RST_REL_HI;
      irq_release_sel_lo <= `KPS_RST_REL_LO;
      key_data_r         <= 16'h0000;
    end else begin
      if (wr_mask)
        key_mask_bits <= reg_wdata;
      if (wr_ctrl) begin
        stop_r          <= reg_wdata[`KPS_CTRL_SCS]; // [RULE2] [RULE3]
        debounce_select <= reg_wdata[`KPS_CTRL_DB_HI:`KPS_CTRL_DB_LO];
      end
      if (wr_sec) begin
        irq_release_sel_hi <= reg_wdata[`KPS_SEC_HI]; // [RULE12]
        irq_release_sel_lo <= reg_wdata[`KPS_SEC_LO]; // [RULE12]
      end
      if (latch_ev)
        key_data_r <= key_word; // [RULE9] [RULE18]
    end
  end

  // ****************************************************************
  // Interrupt and data-available
  // ****************************************************************
  assign rel_c_en = !irq_release_sel_lo; // [RULE16]
  assign rel_d_en = irq_release_sel_hi;  // [RULE16]
  assign irq_clr  = stop_wr || (release_c && rel_c_en)
                    || (rd_data && rel_d_en); // [RULE15]

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_act_r <= 1'b0; // [RULE14]
      avail_r   <= 1'b0;
    end else if (soft_rst) begin
      irq_act_r <= 1'b0; // [RULE14]
      avail_r   <= 1'b0;
    end else begin
      // A new press wins over a key-data read in the same cycle; a stop write blocks the press
      if (latch_ev)
        irq_act_r <= 1'b1; // [RULE13]
      else if (irq_clr)
        irq_act_r <= 1'b0; // [RULE13]
      if (latch_ev)
        avail_r <= 1'b1;
      else if (rd_data)
        avail_r <= 1'b0;
    end
  end

  assign key_irq_n          = !irq_act_r;   // [RULE13]
  assign key_pressed_status = irq_act_r;    // [RULE17]
  assign scan_busy_stop     = !busy;        // [RULE1]
  assign data_avail_pin     = !avail_r;
  assign data_avail_status  = data_avail_pin; // [RULE11]

  // ****************************************************************
  // Read data, valid the cycle after the read strobe
  // ****************************************************************
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= 16'h0000;
      if (reg_page == `KPS_PAGE_DATA) begin
        if (reg_addr == `KPS_ADDR_KEYDATA)
          reg_rdata <= key_data_r;
      end else begin
        case (reg_addr)
          `KPS_ADDR_KEYCTRL: begin
            reg_rdata[`KPS_CTRL_STATUS] <= key_pressed_status;
            reg_rdata[`KPS_CTRL_SCS]    <= scan_busy_stop; // [RULE1]
            reg_rdata[`KPS_CTRL_DB_HI:`KPS_CTRL_DB_LO] <= debounce_select;
          end
          `KPS_ADDR_SECCFG: begin
            reg_rdata[`KPS_SEC_HI] <= data_avail_status; // [RULE11]
            reg_rdata[`KPS_SEC_LO] <= irq_release_sel_lo;
          end
          `KPS_ADDR_KEYMASK: reg_rdata <= key_mask_bits;
          default:           reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule // kps_scan
`default_nettype wire

// ===== sim/kps_scan_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module kps_scan_monitor (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rstn,
  // Register port
  input wire logic        reg_page,
  input wire logic [5:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // Matrix and status pins
  input wire logic [3:0]  row_drive_n,
  input wire logic [3:0]  col_sense_n,
  input wire logic        key_irq_n,
  input wire logic        data_avail_pin
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // ****************************************************************
  // Steps
  // ****************************************************************
  sequence s_stop;
    reg_wr && reg_page && reg_addr == 6'h01 && reg_wdata[14];
  endsequence
  sequence s_srst;
    reg_wr && reg_page && reg_addr == 6'h04 && reg_wdata == 16'hBB00;
  endsequence
  sequence s_stopped;
    s_stop ##1 (!reg_wr [*8]);
  endsequence

  wire rd_ctrl = reg_rd && reg_page && reg_addr == 6'h01;
  wire rd_sec  = reg_rd && reg_page && reg_addr == 6'h06;

  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_stop;
    s_stop |=> key_irq_n && row_drive_n == 4'hF;
  endproperty
  a_stop: assert property (p_stop) else $error("stop write ignored");
  property p_stopped;
    s_stopped |-> row_drive_n == 4'hF && key_irq_n;
  endproperty
  a_stopped: assert property (p_stopped) else $error("scan after stop");
  property p_srst;
    s_srst |=> key_irq_n && data_avail_pin;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset ignored");
  property p_stc;
    rd_ctrl |=> reg_rdata[15] == !$past(key_irq_n);
  endproperty
  a_stc: assert property (p_stc) else $error("status not irq inverse");
  property p_data_avail_status;
    rd_sec |=> reg_rdata[15] == $past(data_avail_pin);
  endproperty
  a_data_avail_status: assert property (p_data_avail_status) else $error("sec bit15 not pin");
  property p_fall;
    $fell(key_irq_n) |-> ##[0:1] !data_avail_pin;
  endproperty
  a_fall: assert property (p_fall) else $error("irq without data");
  property p_busy;
    rd_ctrl && $onehot(~row_drive_n) |=> !reg_rdata[14];
  endproperty
  a_busy: assert property (p_busy) else $error("busy not shown");
  property p_idle;
    rd_ctrl && row_drive_n == 4'hF && $past(row_drive_n) == 4'hF
      |=> reg_rdata[14];
  endproperty
  a_idle: assert property (p_idle) else $error("idle not shown");
  property p_rows;
    $onehot0(~row_drive_n) || row_drive_n == 4'h0;
  endproperty
  a_rows: assert property (p_rows) else $error("two rows driven");
endmodule // kps_scan_monitor
`default_nettype wire

// ===== sim/kps_key_matrix.sv
`timescale 1ns/1ps
`default_nettype none
module kps_key_matrix (
  // Held keys, bit 4*row+col
  input  wire logic [15:0] keys,
  // Matrix pins
  input  wire logic [3:0]  row_drive_n,
  output var  logic [3:0]  col_sense_n
);
  // Pulled-up columns read high when no driven row closes them;
  // no back paths, so rectangles must be avoided by callers
  always_comb begin
    col_sense_n = 4'hF;
    for (int r = 0; r < 4; r++) begin
      for (int c = 0; c < 4; c++) begin
        if (keys[4*r+c] && !row_drive_n[r]) begin
          col_sense_n[c] = 1'b0;
        end
      end
    end
  end
endmodule // kps_key_matrix
`default_nettype wire

// ===== sim/keypad_scan_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
bind kps_scan kps_scan_monitor mon_u (.clk_sys(clk_sys), .rstn(rstn),
  .reg_page(reg_page), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .row_drive_n(row_drive_n), .col_sense_n(col_sense_n),
  .key_irq_n(key_irq_n), .data_avail_pin(data_avail_pin));
module keypad_scan_control_bench;
  localparam int MS = 10;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        reg_page = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [5:0]  reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] keys = 16'h0000;
  logic [15:0] rd;
  wire  [15:0] reg_rdata;
  wire  [3:0]  row_drive_n;
  wire  [3:0]  col_sense_n;
  wire         key_irq_n;
  wire         data_avail_pin;
  int          num_errors = 0;
  int          comparisons = 0;
  int          n;
  int          db[8] = '{2, 10, 20, 50, 60, 80, 100, 120};

  always #50 clk_sys = ~clk_sys;

  kps_scan #(.MS_CYCLES(MS)) dut_u (.clk_sys(clk_sys), .rstn(rstn),
    .reg_page(reg_page), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .row_drive_n(row_drive_n), .col_sense_n(col_sense_n),
    .key_irq_n(key_irq_n), .data_avail_pin(data_avail_pin));
  kps_key_matrix mat_u (.keys(keys), .row_drive_n(row_drive_n),
    .col_sense_n(col_sense_n));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic wr(input logic pg, input logic [5:0] a,
                    input logic [15:0] d);
    @(posedge clk_sys);
    reg_page <= pg;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rdr(input logic pg, input logic [5:0] a);
    @(posedge clk_sys);
    reg_page <= pg;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  task automatic press(input logic [15:0] v);
    @(posedge clk_sys);
    keys <= v;
  endtask
  // Bounded so a dead scanner cannot hang the run
  task automatic wait_irq(output int c);
    c = 0;
    while (key_irq_n !== 1'b0 && c < 2000) begin
      idle(1);
      c++;
    end
    chk_pin("irq asserted", 1'b0, key_irq_n);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    rdr(1'b1, 6'h01); chk("ctrl", 16'h4000, rd);
    rdr(1'b1, 6'h10); chk("mask", 16'h0000, rd);
    rdr(1'b1, 6'h06); chk("sec", 16'hC000, rd);
    rdr(1'b0, 6'h04); chk("data", 16'h0000, rd);
    for (int i = 0; i < 8; i++) begin
      wr(1'b1, 6'h01, {2'b00, i[2:0], 11'h000});
      press(16'h0001 << ((5 * i) % 16));
      wait_irq(n);
      chk_pin("early", 1'b1, n >= (db[i] - 1) * MS);
      chk_pin("late", 1'b1, n <= (db[i] + 1) * MS + 120);
      chk_pin("dav low", 1'b0, data_avail_pin);
      rdr(1'b1, 6'h01);
      chk("ctrl held", {2'b10, i[2:0], 11'h000}, rd);
      rdr(1'b0, 6'h04); chk("data", 16'h0001 << ((5 * i) % 16), rd);
      chk_pin("dav read", 1'b1, data_avail_pin);
      chk_pin("irq read", 1'b1, key_irq_n);
      press(16'h0000);
      idle(150);
    end
    wr(1'b1, 6'h01, 16'h0000);
    wr(1'b1, 6'h10, 16'h0001);
    press(16'h0001);
    idle(400);
    chk_pin("masked irq", 1'b1, key_irq_n);
    press(16'h2141);
    wait_irq(n);
    rdr(1'b0, 6'h04); chk("masked data", 16'h2140, rd);
    press(16'h0000);
    wr(1'b1, 6'h10, 16'h0000);
    idle(150);
    for (int s = 0; s < 4; s++) begin
      wr(1'b1, 6'h06, {s[1:0], 14'h0000});
      rdr(1'b1, 6'h06); chk("sec sel", {1'b1, s[0], 14'h0000}, rd);
      press(16'h8000);
      wait_irq(n);
      rdr(1'b0, 6'h04);
      chk_pin("irq read", s[1], key_irq_n);
      press(16'h0000);
      idle(150);
      chk_pin("irq release", s[1] | !s[0], key_irq_n);
      wr(1'b1, 6'h01, 16'h4000);
      chk_pin("irq stop", 1'b1, key_irq_n);
      chk("rows stop", 16'h000F, {12'h000, row_drive_n});
      wr(1'b1, 6'h01, 16'h0000);
      idle(3);
      chk("rows run", 16'h0000, {12'h000, row_drive_n});
    end
    press(16'h0020);
    idle(30);
    wr(1'b1, 6'h01, 16'h4000);
    idle(300);
    chk_pin("irq held stop", 1'b1, key_irq_n);
    rdr(1'b1, 6'h01); chk("ctrl stop", 16'h4000, rd);
    press(16'h0000);
    wr(1'b1, 6'h01, 16'h0000);
    wr(1'b1, 6'h10, 16'h00F0);
    wr(1'b1, 6'h06, 16'h4000);
    press(16'h0400);
    wait_irq(n);
    wr(1'b1, 6'h04, 16'hBB00);
    chk_pin("irq srst", 1'b1, key_irq_n);
    chk_pin("dav srst", 1'b1, data_avail_pin);
    rdr(1'b1, 6'h10); chk("mask srst", 16'h0000, rd);
    rdr(1'b1, 6'h06); chk("sec srst", 16'hC000, rd);
    wait_irq(n);
    @(posedge clk_sys);
    rstn <= 1'b0;
    idle(2);
    chk_pin("irq hw rst", 1'b1, key_irq_n);
    chk_pin("dav hw rst", 1'b1, data_avail_pin);
    @(posedge clk_sys);
    rstn <= 1'b1;
    press(16'h0000);
    give_verdict();
  end

  initial begin
    #(40000 * 100);
    num_errors++;
    give_verdict();
  end
endmodule // keypad_scan_control_bench
`default_nettype wire
